// ---- shared/acc_pkg.sv ----
// package: constants, commands and carriers for the converter/comparator control block
package acc_pkg;
  localparam int RES_W         = 10;
  localparam int REG_W         = 4;
  localparam int MODE_BIT      = 3;
  localparam int CMP0_EN_BIT   = 2;
  localparam int CMP1_EN_BIT   = 3;
  localparam int CMP_RES_LO    = 0;
  localparam int CMP_RES_HI    = 1;
  localparam int SAR_CYCLES    = 10;
  localparam logic [3:0] CTRL1_RST = 4'h0;
  localparam logic [3:0] MODE_RST  = 4'h0;
  localparam logic [3:0] CMPC_RST  = 4'h0;
  localparam logic [9:0] RES_RST   = 10'h000;

  typedef enum logic [3:0] {
    ACC_NOP, ACC_WR_CTRL1, ACC_RD_CTRL1, ACC_WR_MODE, ACC_RD_MODE,
    ACC_WR_CMPC, ACC_RD_CMPC, ACC_RD_RES_HI, ACC_RD_RES_LO2,
    ACC_WR_RES, ACC_START, ACC_SKIP_DONE
  } acc_cmd_type;

  typedef struct packed {
    acc_cmd_type cmd;
    logic [3:0]  acc_a;
    logic [3:0]  acc_b;
  } acc_req_type;

  typedef struct packed {
    logic [3:0] acc_a;
    logic [3:0] acc_b;
    logic       skip;
    logic       valid;
  } acc_rsp_type;
endpackage : acc_pkg

// ---- core/acc_ctrl.sv ----
// converter and comparator control: registers, sequencer, done flag, port-four sharing
// Operation
// RULE1 - mode bit 3 picks comparator or conversion; leaving comparator may set done flag
// RULE2 - software clears converter interrupt mask bit 2 before leaving comparator mode
// RULE3 - after writing mode register software runs skip instruction to drop stray flag
// RULE4 - software never flips the mode bit while the converter is busy
// RULE5 - low-bits move puts result bits 1:0 into accumulator 3:2, zeros below
// RULE6 - analog-selected pins still act as port four; software drives them high
// RULE7 - port input read of an analog-selected pin returns an undefined value
// RULE8 - enabled comparators keep running in RAM back-up power-down
// RULE9 - comparator control bits 2 and 3 enable the two comparators
// RULE10 - comparator control bits 0 and 1 are read-only results
// RULE11 - software waits 20 us after enabling before reading comparator results
// RULE12 - result register is 10 bits, control registers are 4 bits each
// RULE13 - done flag sets at conversion end and holds until tested; here a start command also clears it
// RULE14 - skip instruction skips when flag is one and clears it
`timescale 1ns/10ps
`default_nettype none
module acc_ctrl #(
  parameter int RES_W = acc_pkg::RES_W
) (
  input  wire logic           sys_clk,       // system clock
  input  wire logic           rst_b,         // async reset, active low
  input  wire acc_pkg::acc_req_type req,     // transfer instruction and accumulator
  input  wire logic           power_down,    // ram back-up state
  input  wire logic           cmp_above_0,   // comparator 0 analog result
  input  wire logic           cmp_above_1,   // comparator 1 analog result
  input  wire logic           sar_above,     // sar comparator: input at or above trial
  input  wire logic [3:0]     port_four_pin, // port four pin levels
  output var acc_pkg::acc_rsp_type rsp,      // registered answer
  output logic [9:0]          sar_trial,     // trial code to the dac
  output logic                cmp_en_0,      // comparator 0 powered
  output logic                cmp_en_1,      // comparator 1 powered
  output logic                done_irq,      // conversion-done flag level
  output logic [3:0]          port_four_in   // port input as seen by software
);
  initial begin
    if (RES_W != 10) $error("acc_ctrl supports a 10-bit result only");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_CONV} acc_st_type;

  // RULE12 register widths
  logic [3:0]  ctrl1_q, ctrl1_d;
  logic [3:0]  mode_q, mode_d;
  logic [1:0]  cmpen_q, cmpen_d;
  logic [1:0]  cmpres_q, cmpres_d;
  logic [9:0]  res_q, res_d;
  logic [9:0]  trial_q, trial_d;
  logic [3:0]  bit_q, bit_d;
  logic        done_q, done_d;
  acc_st_type  st_q, st_d;
  acc_pkg::acc_rsp_type rsp_q, rsp_d;
  logic [3:0]  pin_in_q, pin_in_d;
  logic        sar_end;

  always_comb begin
    ctrl1_d  = ctrl1_q;
    mode_d   = mode_q;
    cmpen_d  = cmpen_q;
    res_d    = res_q;
    trial_d  = trial_q;
    bit_d    = bit_q;
    done_d   = done_q;
    st_d     = st_q;
    sar_end  = 1'b0;
    rsp_d    = '0;
    // RULE8 comparators ignore power-down
    cmpres_d = {cmpen_q[1] ? cmp_above_1 : cmpres_q[1],
                cmpen_q[0] ? cmp_above_0 : cmpres_q[0]};
    // RULE13 successive approximation steps
    unique case (st_q)
      ST_IDLE: begin
      end
      ST_CONV: begin
        if (!sar_above) trial_d[bit_q] = 1'b0;
        if (bit_q == 4'h0) begin
          sar_end = 1'b1;
          st_d    = ST_IDLE;
        end else begin
          trial_d[bit_q - 4'h1] = 1'b1;
          bit_d = bit_q - 4'h1;
        end
      end
    endcase
    if (sar_end) begin
      res_d  = trial_d;
    end
    unique case (req.cmd)
      acc_pkg::ACC_WR_CTRL1: ctrl1_d = req.acc_a;
      acc_pkg::ACC_RD_CTRL1: begin
        rsp_d.acc_a = ctrl1_q;
        rsp_d.valid = 1'b1;
      end
      acc_pkg::ACC_WR_MODE: mode_d = req.acc_a;
      acc_pkg::ACC_RD_MODE: begin
        rsp_d.acc_a = mode_q;
        rsp_d.valid = 1'b1;
      end
      // RULE9 enables from bits 2 and 3
      acc_pkg::ACC_WR_CMPC: cmpen_d = {req.acc_a[acc_pkg::CMP1_EN_BIT],
                                       req.acc_a[acc_pkg::CMP0_EN_BIT]};
      // RULE10 result bits read-only
      acc_pkg::ACC_RD_CMPC: begin
        rsp_d.acc_a = {cmpen_q, cmpres_q};
        rsp_d.valid = 1'b1;
      end
      acc_pkg::ACC_RD_RES_HI: begin
        // comparator mode reads the low byte, conversion mode the top eight bits
        if (mode_q[acc_pkg::MODE_BIT]) begin
          rsp_d.acc_a = res_q[3:0];
          rsp_d.acc_b = res_q[7:4];
        end else begin
          rsp_d.acc_a = res_q[5:2];
          rsp_d.acc_b = res_q[9:6];
        end
        rsp_d.valid = 1'b1;
      end
      // RULE5 low bits to top of accumulator
      acc_pkg::ACC_RD_RES_LO2: begin
        rsp_d.acc_a = {res_q[1:0], 2'b00};
        rsp_d.valid = 1'b1;
      end
      acc_pkg::ACC_WR_RES: res_d = {res_q[9:8], req.acc_b, req.acc_a};
      acc_pkg::ACC_START: begin
        done_d  = 1'b0;
        st_d    = ST_CONV;
        bit_d   = 4'h9;
        trial_d = 10'h200;
      end
      // RULE14 skip and clear
      acc_pkg::ACC_SKIP_DONE: begin
        rsp_d.skip  = done_q;
        rsp_d.valid = 1'b1;
        done_d      = 1'b0;
      end
      default: begin
      end
    endcase
    // RULE1 leaving comparator mode raises stray flag
    if (req.cmd == acc_pkg::ACC_WR_MODE && mode_q[acc_pkg::MODE_BIT]
        && !req.acc_a[acc_pkg::MODE_BIT]) begin
      done_d = 1'b1;
    end
    // RULE13 set wins over clear
    if (sar_end) done_d = 1'b1;
    // RULE6 analog pins keep port function; RULE7 analog read undefined, shown as zero
    pin_in_d = port_four_pin & ~ctrl1_q;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_q  <= acc_pkg::CTRL1_RST;
      mode_q   <= acc_pkg::MODE_RST;
      cmpen_q  <= 2'b00;
      cmpres_q <= 2'b00;
      res_q    <= acc_pkg::RES_RST;
      trial_q  <= 10'h000;
      bit_q    <= 4'h0;
      done_q   <= 1'b0;
      st_q     <= ST_IDLE;
      rsp_q    <= '0;
      pin_in_q <= 4'h0;
    end else begin
      ctrl1_q  <= ctrl1_d;
      mode_q   <= mode_d;
      cmpen_q  <= cmpen_d;
      cmpres_q <= cmpres_d;
      res_q    <= res_d;
      trial_q  <= trial_d;
      bit_q    <= bit_d;
      done_q   <= done_d;
      st_q     <= st_d;
      rsp_q    <= rsp_d;
      pin_in_q <= pin_in_d;
    end
  end

  assign rsp          = rsp_q;
  assign sar_trial    = trial_q;
  assign cmp_en_0     = cmpen_q[0];
  assign cmp_en_1     = cmpen_q[1];
  assign done_irq     = done_q;
  assign port_four_in = pin_in_q;
endmodule : acc_ctrl
`default_nettype wire

// ---- test/acc_monitor.sv ----
// port checker for the converter control block
`timescale 1ns/10ps
`default_nettype none
module acc_monitor (
  input wire logic                 sys_clk,    // clock
  input wire logic                 rst_b,      // reset
  input wire acc_pkg::acc_req_type req,        // request
  input wire logic                 power_down, // back-up
  input wire acc_pkg::acc_rsp_type rsp,        // answer
  input wire logic [9:0]           sar_trial,  // trial
  input wire logic                 cmp_en_0,   // enable 0
  input wire logic                 cmp_en_1,   // enable 1
  input wire logic                 done_irq    // flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_go; req.cmd == acc_pkg::ACC_START; endsequence
  sequence s_steps; sar_trial == 10'h200 ##10 done_irq; endsequence
  a_conv_steps: assert property (s_go |=> s_steps)
    else $error("conversion timing wrong");
  a_rsp_next: assert property (req.cmd == acc_pkg::ACC_RD_MODE |=> rsp.valid)
    else $error("no answer");
  a_low_zero: assert property (req.cmd == acc_pkg::ACC_RD_RES_LO2 |=> rsp.acc_a[1:0] == 2'h0)
    else $error("low bits not zero");
  a_skip_flag: assert property (req.cmd == acc_pkg::ACC_SKIP_DONE && done_irq |=> rsp.skip)
    else $error("skip missed");
  a_done_hold: assert property (done_irq && req.cmd != acc_pkg::ACC_SKIP_DONE
    && req.cmd != acc_pkg::ACC_START |=> done_irq)
    else $error("flag dropped");
  a_en_follow: assert property (req.cmd == acc_pkg::ACC_WR_CMPC |=>
    cmp_en_0 == $past(req.acc_a[2]) && cmp_en_1 == $past(req.acc_a[3]))
    else $error("enable wrong");
  a_en_read: assert property (req.cmd == acc_pkg::ACC_RD_CMPC |=>
    rsp.acc_a[3:2] == {cmp_en_1, cmp_en_0})
    else $error("enable readback wrong");
  a_pd_keep: assert property ($rose(power_down) && req.cmd == acc_pkg::ACC_NOP |=>
    $stable({cmp_en_1, cmp_en_0}))
    else $error("comparator stopped");
endmodule : acc_monitor
`default_nettype wire

// ---- test/acc_analog_src.sv ----
// analog sources on the shared pins
`timescale 1ns/10ps
`default_nettype none
module acc_analog_src (
  input wire logic [9:0] level,       // input as a code
  input wire logic [9:0] sar_trial,   // trial code
  output logic           sar_above,   // at or above trial
  output logic           cmp_above_0, // comparator 0
  output logic           cmp_above_1  // comparator 1
);
  assign sar_above = level >= sar_trial;
  assign cmp_above_0 = level[9];
  assign cmp_above_1 = level[8];
endmodule : acc_analog_src
`default_nettype wire

// ---- test/tb_adc_comparator_control.sv ----
// testbench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb_adc_comparator_control;
  logic sys_clk = 0, rst_b = 0, power_down = 0, sar_above, cmp_above_0, cmp_above_1;
  logic cmp_en_0, cmp_en_1, done_irq;
  logic [3:0] pin = 0, pin_in;
  logic [9:0] level = 0, sar_trial, r;
  int failures = 0, checked = 0, seed = 1752, cyc = 0;
  acc_pkg::acc_req_type req = '0;
  acc_pkg::acc_rsp_type rsp;
  always #2.5 sys_clk = ~sys_clk;
  acc_analog_src SRC (.level, .sar_trial, .sar_above, .cmp_above_0, .cmp_above_1);
  acc_ctrl DUT (.sys_clk, .rst_b, .req, .power_down, .cmp_above_0, .cmp_above_1,
    .sar_above, .port_four_pin(pin), .rsp, .sar_trial, .cmp_en_0, .cmp_en_1,
    .done_irq, .port_four_in(pin_in));
  task chk(string n, logic [9:0] s, logic [9:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task op(acc_pkg::acc_cmd_type c, logic [3:0] a = 0, logic [3:0] b = 0);
    @(negedge sys_clk);
    req = '{c, a, b};
    @(negedge sys_clk);
    req = '0;
  endtask : op
  task end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim;
    end
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    rst_b = 1;
    level = 10'($random(seed));
    op(acc_pkg::ACC_WR_CMPC, {2'h3, ~level[8], ~level[9]});
    chk("en", {cmp_en_1, cmp_en_0}, 2'h3);
    // response time of 20 us before results are read
    repeat (4000) @(negedge sys_clk);
    op(acc_pkg::ACC_RD_CMPC);
    chk("cmpc", rsp.acc_a, {2'h3, level[8], level[9]});
    power_down = 1;
    repeat (3) @(negedge sys_clk);
    chk("pd", {cmp_en_1, cmp_en_0}, 2'h3);
    op(acc_pkg::ACC_WR_CMPC);
    chk("off", {cmp_en_1, cmp_en_0}, 2'h0);
    power_down = 0;
    for (int i = 0; i < 6; i++) begin
      level = (i < 2) ? {10{i[0]}} : 10'($random(seed));
      op(acc_pkg::ACC_START);
      repeat (9) @(negedge sys_clk);
      chk("busy", done_irq, 0);
      @(negedge sys_clk);
      chk("done", done_irq, 1);
      op(acc_pkg::ACC_RD_RES_HI);
      chk("hi", {rsp.acc_b, rsp.acc_a}, level[9:2]);
      op(acc_pkg::ACC_RD_RES_LO2);
      chk("lo", rsp.acc_a, {level[1:0], 2'h0});
      op(acc_pkg::ACC_SKIP_DONE);
      chk("skip", {rsp.skip, done_irq}, 2'h2);
    end
    op(acc_pkg::ACC_SKIP_DONE);
    chk("noskip", rsp.skip, 0);
    r = 10'($random(seed));
    // mode only changed while the converter is idle
    op(acc_pkg::ACC_WR_MODE, 4'h8);
    op(acc_pkg::ACC_WR_RES, r[3:0], r[7:4]);
    op(acc_pkg::ACC_RD_RES_HI);
    chk("cmode", {rsp.acc_b, rsp.acc_a}, r[7:0]);
    // interrupt mask is cleared by software outside this block first
    op(acc_pkg::ACC_WR_MODE);
    op(acc_pkg::ACC_SKIP_DONE);
    chk("stray", {rsp.skip, done_irq}, 2'h2);
    for (int i = 0; i < 4; i++) begin
      r = 10'($random(seed));
      op(acc_pkg::ACC_WR_CTRL1, r[3:0]);
      pin = r[7:4] | r[3:0];
      op(acc_pkg::ACC_RD_CTRL1);
      chk("ctrl1", rsp.acc_a, r[3:0]);
      chk("port", pin_in, pin & ~r[3:0]);
    end
    end_sim;
  end
endmodule : tb_adc_comparator_control
bind acc_ctrl acc_monitor MON (.sys_clk, .rst_b, .req, .power_down, .rsp,
  .sar_trial, .cmp_en_0, .cmp_en_1, .done_irq);
`default_nettype wire
